/* File: hdl/srsf_status.sv */
/*
  Receive status flags of the serial interface: address/data bit,
  framing, parity and overrun errors, receive-full, the receive data
  register, its read-sequence clearing and a maskable interrupt.
  Assumes the receive shifter sits on the same clock and pulses
  rx_char_ready for one cycle with the frame's fields beside it; the
  control inputs come from same-clock logic, so none is synchronised.
*/
// Added by the designer: the register addresses and the address-and-strobe port.
`include "srsf_cfg.svh"

// Behaviour
// - status register read-only, bits 23..8 zero
// - multidrop: bit 7 one for address
// - reads leave address/data bit alone
// - resets and stop clear bit7, framing, parity
// - async missing stop sets framing with full
// - framing flag blocks further data transfers
// - framing clears by status then data read
// - 8-bit synchronous: framing flag always zero
// - framing plus overrun reports overrun only
// - parity modes: wrong parity sets flag
// - parity flag does not block transfers
// - parity clears by status then data read
// - modes without parity keep parity zero
// - parity plus overrun reports overrun only
// - ready while full: overrun, drop the byte
// - full set on transfer, cleared by read
// - word-select code 6 is multidrop framing
module srsf_status
  import srsf_pkg::*;
#(
  parameter int DATA_W = 24,
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  input  wire logic [2:0]        word_mode,
  input  wire logic              rx_char_ready,
  input  wire logic [7:0]        rx_shift_data,
  input  wire logic              rx_stop_ok,
  input  wire logic              rx_ninth_bit,
  input  wire logic              soft_reset,
  input  wire logic              indiv_reset,
  input  wire logic              stop_req,
  input  wire logic              line_idle,
  input  wire logic              tx_holding_empty_flag,
  input  wire logic              transmitter_empty_flag,
  output logic                   rx_full_flag,
  output logic                   rx_transfer,
  output logic                   irq
);

  // state
  logic            rx_addr_data_bit;
  logic            framing_error_flag;
  logic            parity_error_flag;
  logic            overrun_flag;
  logic [7:0]      rx_data_register;
  srsf_seq_e       seq;
  srsf_ev_t        irq_status;
  srsf_ev_t        irq_enable;

  // next values
  logic            next_addr_data;
  logic            next_frame;
  logic            next_parity;
  logic            next_overrun;
  logic            next_full;
  logic [7:0]      next_rx_data;
  srsf_seq_e       next_seq;
  srsf_ev_t        next_irq_status;
  srsf_ev_t        next_irq_enable;
  logic [DATA_W-1:0] next_rdata;
  logic [DATA_W-1:0] status_word;

  // address decode
  wire sel_status   = addr == ADDR_W'(`SRSF_OFF_STATUS);
  wire sel_rxdata   = addr == ADDR_W'(`SRSF_OFF_RXDATA);
  wire sel_irq_stat = addr == ADDR_W'(`SRSF_OFF_IRQ_STAT);
  wire sel_irq_en   = addr == ADDR_W'(`SRSF_OFF_IRQ_EN);
  wire sel_irq_clr  = addr == ADDR_W'(`SRSF_OFF_IRQ_CLR);

  wire status_rd = rd & sel_status;
  wire data_rd   = rd & sel_rxdata;
  wire en_wr     = wr & sel_irq_en;
  wire clr_wr    = wr & sel_irq_clr;

  // mode decode
  wire mode_sync8     = word_mode == `SRSF_MODE_SYNC8;
  wire mode_even      = word_mode == `SRSF_MODE_EVEN11;
  wire mode_odd       = word_mode == `SRSF_MODE_ODD11;
  wire mode_multidrop = word_mode == `SRSF_MODE_MULTIDROP;
  wire mode_parity    = mode_even | mode_odd;
  wire mode_async     = !mode_sync8;

  // reset, software reset, interface reset and stop all clear
  wire clr_all = soft_reset | indiv_reset | stop_req;

  // receive path decisions
  // overrun wins: the byte is never transferred, so its framing and
  // parity findings are never recorded
  wire char_overrun = rx_char_ready & rx_full_flag;
  // a pending framing error holds off new words; they are lost
  wire char_blocked = rx_char_ready & !rx_full_flag
                      & framing_error_flag;
  // parity error does not appear in the transfer condition
  wire char_take    = rx_char_ready & !rx_full_flag
                      & !char_blocked;

  // even parity: data plus parity bit has an even number of ones
  wire parity_ones = ^{rx_shift_data, rx_ninth_bit};
  wire parity_bad  = mode_even ? parity_ones : !parity_ones;

  wire frame_set   = char_take & mode_async & !rx_stop_ok;
  wire parity_set  = char_take & mode_parity & parity_bad;
  wire overrun_set = char_overrun;

  // status read then data read clears the error flags
  wire seq_fire = data_rd & (seq == SRSF_SEQ_ARMED);

  assign rx_transfer = char_take;

  // address/data bit only moves on a multidrop transfer or a reset or stop
  always_comb begin
    next_addr_data = rx_addr_data_bit;
    if (clr_all) begin
      next_addr_data = `SRSF_FLAG_RST;
    end else if (char_take & mode_multidrop) begin
      next_addr_data = rx_ninth_bit;
    end
  end

  // set wins over the read-sequence clear
  always_comb begin
    next_frame = framing_error_flag;
    if (clr_all) begin
      next_frame = `SRSF_FLAG_RST;
    end else if (mode_sync8) begin
      next_frame = 1'b0;
    end else if (frame_set) begin
      next_frame = 1'b1;
    end else if (seq_fire) begin
      next_frame = 1'b0;
    end
  end

  always_comb begin
    next_parity = parity_error_flag;
    if (clr_all) begin
      next_parity = `SRSF_FLAG_RST;
    end else if (!mode_parity) begin
      next_parity = 1'b0;
    end else if (parity_set) begin
      next_parity = 1'b1;
    end else if (seq_fire) begin
      next_parity = 1'b0;
    end
  end

  always_comb begin
    next_overrun = overrun_flag;
    if (clr_all) begin
      next_overrun = `SRSF_FLAG_RST;
    end else if (overrun_set) begin
      next_overrun = 1'b1;
    end else if (seq_fire) begin
      next_overrun = 1'b0;
    end
  end

  // a transfer in the reading cycle happens only while the register is
  // empty, and then it wins over the read; a full register turns that byte into an overrun instead
  always_comb begin
    next_full    = rx_full_flag;
    next_rx_data = rx_data_register;
    if (char_take) begin
      next_full    = 1'b1;
      next_rx_data = rx_shift_data;
    end else if (data_rd) begin
      next_full = 1'b0;
    end
  end

  always_comb begin
    next_seq = seq;
    unique case (seq)
      SRSF_SEQ_IDLE: begin
        if (status_rd) begin
          next_seq = SRSF_SEQ_ARMED;
        end
      end
      SRSF_SEQ_ARMED: begin
        if (data_rd) begin
          next_seq = SRSF_SEQ_IDLE;
        end
      end
      default: begin
        next_seq = SRSF_SEQ_IDLE;
      end
    endcase
  end

  // interrupt events: sticky, set wins over a clear write
  wire [`SRSF_EV_W-1:0] ev;
  assign ev[`SRSF_EV_FULL]    = char_take;
  assign ev[`SRSF_EV_FRAME]   = frame_set;
  assign ev[`SRSF_EV_PARITY]  = parity_set;
  assign ev[`SRSF_EV_OVERRUN] = overrun_set;

  wire [`SRSF_EV_W-1:0] clr_mask = clr_wr ? wdata[`SRSF_EV_W-1:0]
                                          : {`SRSF_EV_W{1'b0}};

  assign next_irq_status = (irq_status & ~clr_mask) | ev;
  assign next_irq_enable = en_wr ? wdata[`SRSF_EV_W-1:0] : irq_enable;

  assign irq = |(irq_status & irq_enable);

  // status word: only the low byte carries flags
  always_comb begin
    status_word                      = {DATA_W{1'b0}};
    status_word[`SRSF_BIT_ADDR_DATA] = rx_addr_data_bit;
    status_word[`SRSF_BIT_FRAME]     = framing_error_flag;
    status_word[`SRSF_BIT_PARITY]    = parity_error_flag;
    status_word[`SRSF_BIT_OVERRUN]   = overrun_flag;
    status_word[`SRSF_BIT_IDLE]      = line_idle;
    status_word[`SRSF_BIT_FULL]      = rx_full_flag;
    status_word[`SRSF_BIT_TX_HOLD]   = tx_holding_empty_flag;
    status_word[`SRSF_BIT_TX_EMPTY]  = transmitter_empty_flag;
  end

  // read mux; unmapped and write-only offsets read zero
  always_comb begin
    next_rdata = {DATA_W{1'b0}};
    if (rd) begin
      if (sel_status) begin
        next_rdata = status_word;
      end else if (sel_rxdata) begin
        next_rdata = {{(DATA_W-8){1'b0}}, rx_data_register};
      end else if (sel_irq_stat) begin
        next_rdata = {{(DATA_W-`SRSF_EV_W){1'b0}}, irq_status};
      end else if (sel_irq_en) begin
        next_rdata = {{(DATA_W-`SRSF_EV_W){1'b0}}, irq_enable};
      end
    end
  end

  // address/data bit: cleared by every reset source, kept by reads
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_addr_data_bit <= `SRSF_FLAG_RST;
    end else begin
      rx_addr_data_bit <= next_addr_data;
    end
  end

  // framing flag; while set it holds the receive path shut
  always_ff @(posedge clk) begin
    if (rst) begin
      framing_error_flag <= `SRSF_FLAG_RST;
    end else begin
      framing_error_flag <= next_frame;
    end
  end

  // parity flag; never holds the receive path shut
  always_ff @(posedge clk) begin
    if (rst) begin
      parity_error_flag <= `SRSF_FLAG_RST;
    end else begin
      parity_error_flag <= next_parity;
    end
  end

  // overrun flag
  always_ff @(posedge clk) begin
    if (rst) begin
      overrun_flag <= `SRSF_FLAG_RST;
    end else begin
      overrun_flag <= next_overrun;
    end
  end

  // receive-full: a data read or rst empties it, soft resets keep the byte
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_full_flag <= `SRSF_FLAG_RST;
    end else begin
      rx_full_flag <= next_full;
    end
  end

  // held byte; stays readable after an overrun drops its successor
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_data_register <= `SRSF_BYTE_RST;
    end else begin
      rx_data_register <= next_rx_data;
    end
  end

  // clear sequence; soft resets leave an armed sequence armed, so a
  // data read right after one still clears the error flags
  always_ff @(posedge clk) begin
    if (rst) begin
      seq <= SRSF_SEQ_IDLE;
    end else begin
      seq <= next_seq;
    end
  end

  // sticky interrupt events, cleared only by software or rst
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_status <= `SRSF_EV_RST;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // interrupt enables; all off after rst so irq starts low
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_enable <= `SRSF_EV_RST;
    end else begin
      irq_enable <= next_irq_enable;
    end
  end

  // read port: registered, zero outside the cycle after a read
  // trade-off: one cycle of latency buys a flop-driven data output
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= {DATA_W{1'b0}};
    end else begin
      rdata <= next_rdata;
    end
  end

endmodule

/* File: hdl/srsf_cfg.svh */
/*
  Constants of the serial receive status block: register offsets, status
  bit positions, reset values and word-select codes.
  Assumes it is included by bare name from the package and the design.
*/
`ifndef SRSF_CFG_SVH
`define SRSF_CFG_SVH

// register offsets (byte addresses)
`define SRSF_OFF_STATUS   8'h00
`define SRSF_OFF_RXDATA   8'h04
`define SRSF_OFF_IRQ_STAT 8'h08
`define SRSF_OFF_IRQ_EN   8'h0C
`define SRSF_OFF_IRQ_CLR  8'h10

// status bit positions
`define SRSF_BIT_ADDR_DATA 7
`define SRSF_BIT_FRAME     6
`define SRSF_BIT_PARITY    5
`define SRSF_BIT_OVERRUN   4
`define SRSF_BIT_IDLE      3
`define SRSF_BIT_FULL      2
`define SRSF_BIT_TX_HOLD   1
`define SRSF_BIT_TX_EMPTY  0
`define SRSF_STATUS_USED   8

// interrupt event bit positions
`define SRSF_EV_FULL    0
`define SRSF_EV_FRAME   1
`define SRSF_EV_PARITY  2
`define SRSF_EV_OVERRUN 3
`define SRSF_EV_W       4

// word-select codes
`define SRSF_MODE_SYNC8     3'h0
`define SRSF_MODE_ASYNC10   3'h2
`define SRSF_MODE_EVEN11    3'h4
`define SRSF_MODE_ODD11     3'h5
`define SRSF_MODE_MULTIDROP 3'h6

// reset values
`define SRSF_FLAG_RST  1'b0
`define SRSF_BYTE_RST  8'h00
`define SRSF_EV_RST    4'h0

`endif

/* File: hdl/srsf_pkg.sv */
/*
  Types shared by the serial receive status block.
  Assumes srsf_cfg.svh is on the include path.
*/
`include "srsf_cfg.svh"

package srsf_pkg;

  typedef logic [2:0] srsf_mode_t;
  typedef logic [`SRSF_EV_W-1:0] srsf_ev_t;

  // clear sequence: status read arms, data read fires
  typedef enum logic [1:0] {
    SRSF_SEQ_IDLE  = 2'b01,
    SRSF_SEQ_ARMED = 2'b10
  } srsf_seq_e;

endpackage

/* File: sim/srsf_status_assertions.sv */
/*
  Port-level checks of the receive status block, bound below.
  Assumes one clock and a synchronous active-high reset.
*/
`include "srsf_cfg.svh"
module srsf_status_assertions
  import srsf_pkg::*;
#(
  parameter int DATA_W = 24,
  parameter int ADDR_W = 8
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [2:0]        word_mode,
  input wire logic              rx_char_ready,
  input wire logic              rx_stop_ok,
  input wire logic              rx_ninth_bit,
  input wire logic              rx_full_flag,
  input wire logic              rx_transfer,
  input wire logic              irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire logic rd_st  = rd && addr == `SRSF_OFF_STATUS;
  wire logic no_par = word_mode != `SRSF_MODE_EVEN11 && word_mode != `SRSF_MODE_ODD11;
  a_resv_zero: assert property (rdata[DATA_W-1:8] == '0)
    else $error("reserved status bits not zero");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == '0)
    else $error("read data outside read cycle");
  a_full_set: assert property (rx_transfer |=> rx_full_flag)
    else $error("full not set after transfer");
  a_full_clr: assert property
    (rd && addr == `SRSF_OFF_RXDATA && !rx_transfer |=> !rx_full_flag)
    else $error("full not cleared by data read");
  a_ovr_drop: assert property (rx_char_ready && rx_full_flag |-> !rx_transfer)
    else $error("byte moved while full");
  // one no-read cycle between transfer and status read keeps a quick clear sequence out of the window
  a_frame_set: assert property (rx_transfer && word_mode != `SRSF_MODE_SYNC8
    && !rx_stop_ok ##1 !rd ##1 rd_st |=> rdata[`SRSF_BIT_FRAME])
    else $error("framing flag not set");
  a_mdrop_bit: assert property (rx_transfer && word_mode == `SRSF_MODE_MULTIDROP
    ##1 !rd ##1 rd_st |=> rdata[`SRSF_BIT_ADDR_DATA] == $past(rx_ninth_bit, 3))
    else $error("address bit not captured");
  a_sync_nofe: assert property ($past(rd_st) && $past(word_mode) == `SRSF_MODE_SYNC8
    && $past(word_mode, 2) == `SRSF_MODE_SYNC8 |-> !rdata[`SRSF_BIT_FRAME])
    else $error("framing flag in sync mode");
  a_par_none: assert property
    ($past(rd_st) && $past(no_par) && $past(no_par, 2) |-> !rdata[`SRSF_BIT_PARITY])
    else $error("parity flag without parity");
  a_irq_off: assert property ($past(wr) && $past(addr) == `SRSF_OFF_IRQ_EN
    && $past(wdata[3:0]) == 4'h0 |-> !irq)
    else $error("irq with all enables off");
  c_overrun: cover property (rx_char_ready && rx_full_flag);
  c_mdrop: cover property (rx_transfer && word_mode == `SRSF_MODE_MULTIDROP);
  c_irq: cover property (irq);
endmodule

bind srsf_status srsf_status_assertions #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_chk (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .word_mode(word_mode), .rx_char_ready(rx_char_ready),
  .rx_stop_ok(rx_stop_ok), .rx_ninth_bit(rx_ninth_bit),
  .rx_full_flag(rx_full_flag), .rx_transfer(rx_transfer), .irq(irq)
);

/* File: sim/srsf_rx_model.sv */
/*
  Remote transmitter model: hands one finished character to the block.
  Assumes the bench's clock; the caller spaces characters.
*/
module srsf_rx_model (
  input  wire logic       clk,
  output logic            rdy,
  output logic      [7:0] data,
  output logic            stop_ok,
  output logic            ninth
);
  timeunit 1ns;
  timeprecision 100ps;
  initial rdy = 1'b0;
  initial data = 8'h00;
  initial stop_ok = 1'b1;
  initial ninth = 1'b0;
  // fields are stale after the pulse, so show their inverse
  task automatic send(input logic [7:0] d, input logic s, input logic n);
    @(posedge clk);
    rdy     <= 1'b1;
    data    <= d;
    stop_ok <= s;
    ninth   <= n;
    @(posedge clk);
    rdy     <= 1'b0;
    data    <= ~d;
    stop_ok <= ~s;
    ninth   <= ~n;
  endtask
endmodule

/* File: sim/tb_serial_receive_status_flags.sv */
/*
  Testbench of the receive status flags: bus tasks, scenarios, verdict.
  Assumes srsf_cfg.svh on the include path and the rx model beside it.
*/
`include "srsf_cfg.svh"
module tb_serial_receive_status_flags
  import srsf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] st = `SRSF_OFF_STATUS;
  localparam logic [7:0] dt = `SRSF_OFF_RXDATA;
  logic        clk, rst, wr, rd, idle, txh, txe;
  logic        rdy, sok, nb, rfull, rxt, irq;
  logic [7:0]  addr, sd;
  logic [23:0] wdata, rdata;
  logic [2:0]  src;
  srsf_mode_t  mode;
  int          err_count, n_checks, cyc, n_xfer;
  always #5 clk = ~clk;
  srsf_status dut (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .word_mode(mode), .rx_char_ready(rdy),
    .rx_shift_data(sd), .rx_stop_ok(sok), .rx_ninth_bit(nb),
    .soft_reset(src[0]), .indiv_reset(src[1]), .stop_req(src[2]),
    .line_idle(idle), .tx_holding_empty_flag(txh),
    .transmitter_empty_flag(txe), .rx_full_flag(rfull),
    .rx_transfer(rxt), .irq(irq)
  );
  srsf_rx_model rxm (.clk(clk), .rdy(rdy), .data(sd), .stop_ok(sok), .ninth(nb));
  // count accepted characters; dropped ones must not show up here
  always @(posedge clk) begin
    if (rxt === 1'b1) begin
      n_xfer <= n_xfer + 1;
    end
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [23:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [23:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic t_reset();
    rchk(st, 8'h00);
    rchk(dt, 8'h00);
    rchk(8'h14, 8'h00);
    @(posedge clk) {idle, txh, txe} <= 3'h7;
    wreg(st, 24'h00_00ff);
    rchk(st, 8'h0b);
    // a data read disarms the clear sequence before the next test
    rchk(dt, 8'h00);
    @(posedge clk) {idle, txh, txe} <= 3'h0;
    $display("t_reset done");
  endtask
  task automatic t_frame();
    int x0;
    @(posedge clk) mode <= `SRSF_MODE_ASYNC10;
    x0 = n_xfer;
    wreg(`SRSF_OFF_IRQ_EN, 24'h00_000f);
    rxm.send(8'h41, 1'b0, 1'b0);
    #1 chk(irq, 1'b1);
    rchk(dt, 8'h41);
    rxm.send(8'h42, 1'b1, 1'b0);
    rchk(st, 8'h40);
    rchk(`SRSF_OFF_IRQ_STAT, 8'h03);
    wreg(`SRSF_OFF_IRQ_CLR, 24'h00_000f);
    #1 chk(irq, 1'b0);
    rchk(dt, 8'h41);
    rchk(st, 8'h00);
    rxm.send(8'h43, 1'b1, 1'b0);
    rchk(dt, 8'h43);
    chk(24'(n_xfer - x0), 24'h00_0002);
    wreg(`SRSF_OFF_IRQ_EN, 24'h00_0000);
    $display("t_frame done");
  endtask
  task automatic t_sync();
    @(posedge clk) mode <= `SRSF_MODE_SYNC8;
    rxm.send(8'h5a, 1'b0, 1'b0);
    #1 chk(rfull, 1'b1);
    rchk(st, 8'h04);
    rchk(dt, 8'h5a);
    $display("t_sync done");
  endtask
  task automatic t_parity();
    srsf_mode_t ms[4] = '{`SRSF_MODE_EVEN11, `SRSF_MODE_ODD11,
                          `SRSF_MODE_ASYNC10, `SRSF_MODE_MULTIDROP};
    foreach (ms[i]) begin
      @(posedge clk) mode <= ms[i];
      // first byte carries a wrong parity bit in both parity modes
      rxm.send(8'h01, 1'b1, ms[i] == `SRSF_MODE_ODD11);
      rchk(dt, 8'h01);
      rxm.send(8'h5a, 1'b1, ms[i] == `SRSF_MODE_ODD11);
      rchk(dt, 8'h5a);
      rchk(st, (ms[i] == `SRSF_MODE_EVEN11 || ms[i] == `SRSF_MODE_ODD11)
               ? 8'h20 : 8'h00);
      rchk(dt, 8'h5a);
      rchk(st, 8'h00);
      // a second data read disarms, so the next pass starts unarmed
      rchk(dt, 8'h5a);
    end
    $display("t_parity done");
  endtask
  task automatic t_overrun();
    int x0;
    @(posedge clk) mode <= `SRSF_MODE_EVEN11;
    x0 = n_xfer;
    rxm.send(8'h11, 1'b1, 1'b0);
    rxm.send(8'h22, 1'b0, 1'b1);
    rchk(st, 8'h14);
    chk(24'(n_xfer - x0), 24'h00_0001);
    rchk(dt, 8'h11);
    rchk(st, 8'h00);
    $display("t_overrun done");
  endtask
  task automatic t_mdrop();
    @(posedge clk) mode <= `SRSF_MODE_MULTIDROP;
    for (int i = 0; i < 3; i++) begin
      rxm.send(8'h80, 1'b0, 1'b1);
      rchk(st, 8'hc4);
      @(posedge clk) src[i] <= 1'b1;
      @(posedge clk) src[i] <= 1'b0;
      rchk(st, 8'h04);
      rchk(dt, 8'h80);
    end
    rxm.send(8'h81, 1'b1, 1'b1);
    rchk(dt, 8'h81);
    rchk(st, 8'h80);
    rchk(dt, 8'h81);
    rchk(st, 8'h80);
    $display("t_mdrop done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ceiling well above the under two hundred cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      tally_and_finish();
    end
  end
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {wr, rd, idle, txh, txe, src} = 8'h00;
    addr = 8'h00;
    wdata = 24'h00_0000;
    mode = `SRSF_MODE_ASYNC10;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_frame();
    t_sync();
    t_parity();
    t_overrun();
    t_mdrop();
    tally_and_finish();
  end
endmodule
